// ### dbg_host_model.sv
/*
 * Debugger model: one-cycle CSR requests and resume pulses.
 * Assumes the testbench calls its tasks and the block answers one cycle later.
 */
`timescale 1ns/1ps

module dbg_host_model (
  input  wire logic        ref_clk,
  input  wire logic        debug_mode,
  input  wire logic [31:0] csr_rdata,
  input  wire logic        illegal_insn,
  output dbg_pkg::csr_req_t csr_req,
  output logic             resume_req
);
  initial begin
    csr_req = '0;
    resume_req = 1'b0;
  end

  task automatic access(input logic wr, input logic [11:0] a, input logic [31:0] d,
                        output logic [31:0] rd, output logic ill);
    @(posedge ref_clk);
    // A real debugger never writes the status register while the hart runs.
    if (!(wr && a == dbg_pkg::CSR_STATUS_ADDR && !debug_mode)) begin
      csr_req <= '{valid: 1'b1, write: wr, addr: a, wdata: d};
    end
    @(posedge ref_clk);
    csr_req <= '0;
    #1;
    rd = csr_rdata;
    ill = illegal_insn;
  endtask

  task automatic resume();
    @(posedge ref_clk);
    resume_req <= 1'b1;
    @(posedge ref_clk);
    resume_req <= 1'b0;
  endtask
endmodule

// ### dbg_pkg.sv
/*
 * Shared constants and carrier types for the debug control/status and resume-PC block.
 * Assumes a single-hart, machine-mode-only core with 12-bit CSR addressing.
 */
package dbg_pkg;

  localparam logic [11:0] CSR_STATUS_ADDR = 12'h07b0;
  localparam logic [11:0] CSR_RESUME_PC_ADDR = 12'h07b1;

  localparam int unsigned EBREAKM_BIT = 15;
  localparam int unsigned STEPIE_BIT = 11;
  localparam int unsigned STOPCOUNT_BIT = 10;
  localparam int unsigned STOPTIME_BIT = 9;
  localparam int unsigned CAUSE_LSB = 6;
  localparam int unsigned MPRVEN_BIT = 4;
  localparam int unsigned NMIP_BIT = 3;
  localparam int unsigned STEP_BIT = 2;
  localparam int unsigned PRV_LSB = 0;

  localparam logic [3:0] DEBUGVER_VALUE = 4'h4;
  localparam logic [1:0] PRV_MACHINE = 2'h3;
  localparam logic [31:0] RESUME_PC_RESET = 32'h0000_0000;
  localparam logic [31:0] INSN_BYTES = 32'h0000_0004;

  typedef enum logic [2:0] {
    CAUSE_NONE    = 3'h0,
    CAUSE_EBREAK  = 3'h1,
    CAUSE_TRIGGER = 3'h2,
    CAUSE_HALTREQ = 3'h3,
    CAUSE_STEP    = 3'h4,
    CAUSE_RESET   = 3'h5
  } cause_t;

  typedef enum logic [1:0] {
    ST_RUN    = 2'b00,
    ST_HALTED = 2'b01,
    ST_STEP   = 2'b11
  } hart_state_t;

  // Entry reasons seen in one cycle, with the PC figures each one needs.
  typedef struct packed {
    logic        trigger;
    logic        trigger_timing;
    logic        ebreak;
    logic        reset_halt;
    logic        halt_req;
    logic [31:0] insn_pc;
    logic [31:0] next_pc;
  } entry_t;

  // CSR access from the core pipeline.
  typedef struct packed {
    logic        valid;
    logic        write;
    logic [11:0] addr;
    logic [31:0] wdata;
  } csr_req_t;

endpackage

// ### debug_mode_ctrl.sv
/*
 * Debug-mode control/status register, resume-PC register, entry-cause
 * priority, single-step sequencing and counter/interrupt gating of the hart.
 * Assumes the pipeline reports entry reasons, retirements and exceptions in
 * the ref_clk domain; the NMI-pending level comes from a pin.
 * The debugger reaches both registers through csr_req while the hart is halted.
 */
// How it works
// RL1: Stopcount set freezes cycle and instret counting while halted or entering via ebreak.
// RL2: Stoptime reads zero; timers keep running in debug mode.
// RL3: Cause field records entry reason: 1 ebreak, 2 trigger, 3 halt, 4 step, 5 reset.
// RL4: Simultaneous reasons report priority: trigger, ebreak, reset halt, halt request, step.
// RL5: Reset-halt entry may report code 3; this design reports code 5.
// RL6: Mprven reads zero; mstatus mprv ignored in debug mode.
// RL7: Nmip bit mirrors pending non-maskable interrupt.
// RL8: Step set outside debug mode runs one instruction then halts with cause step.
// RL9: A stepped instruction that traps halts at once before the handler runs.
// RL10: Debugger changes step bit only while hart is halted.
// RL11: Privilege field always reads machine mode, 3, from reset.
// RL12: Halt-request and reset-halt entries load resume PC with next instruction address.
// RL13: Resume loads core PC from resume PC; debugger may rewrite it when halted.
// RL14: Both registers reachable only in debug mode; otherwise illegal instruction.
// RL15: Ebreak entry captures the ebreak instruction's own address.
// RL16: Step entry captures next sequential or taken-target address.
// RL17: Trigger entry captures instruction address when timing is 0, else next address.
// RL18: Ebreakm set sends machine-mode ebreak to debug mode, else normal breakpoint.
// RL19: Stepie clear masks interrupts while stepping.
// RL20: Cause and resume PC change only on entry, or by debugger write of PC.
`timescale 1ns/1ps

module debug_mode_ctrl (
  input  wire logic              ref_clk,
  input  wire logic              rst,
  input  wire dbg_pkg::entry_t   entry,
  input  wire logic              ebreak_exec,
  input  wire logic              insn_retire,
  input  wire logic              step_exception,
  input  wire logic [31:0]       step_next_pc,
  input  wire logic              resume_req,
  input  wire logic              nmi_pending,
  input  wire dbg_pkg::csr_req_t csr_req,
  output logic                   debug_mode,
  output logic                   ebreak_to_debug,
  output logic                   ebreak_to_trap,
  output logic                   resume_valid,
  output logic [31:0]            resume_pc,
  output logic                   count_stop,
  output logic                   irq_mask,
  output logic                   mprv_ignore,
  output logic                   illegal_insn,
  output logic [31:0]            csr_rdata
);

  dbg_pkg::hart_state_t state_r;
  dbg_pkg::hart_state_t state_nxt;
  dbg_pkg::cause_t      cause_r;
  dbg_pkg::cause_t      cause_nxt;
  logic [31:0]          resume_pc_r;
  logic [31:0]          capture_pc;
  logic                 ebreakm_r;
  logic                 stepie_r;
  logic                 stopcount_r;
  logic                 step_r;
  logic                 nmi_meta_r;
  logic                 nmi_sync_r;
  logic                 ebreak_enter;
  logic                 step_done;
  logic                 enter;
  logic                 halted;
  logic                 csr_hit;
  logic                 wr_status;
  logic                 wr_pc;
  logic [31:0]          status_view;

  // Both debug registers share one access check, so the address match lives in one place.
  // A miss here leaves the request to other register files and raises nothing.
  function automatic logic addr_is_debug(input logic [11:0] a);
    addr_is_debug = (a == dbg_pkg::CSR_STATUS_ADDR) || (a == dbg_pkg::CSR_RESUME_PC_ADDR);
  endfunction

  // Entry reasons are ignored while halted, so a late halt request cannot
  // overwrite the cause or resume PC that the debugger is looking at.
  assign halted = (state_r == dbg_pkg::ST_HALTED);
  assign ebreak_enter = ebreak_exec && ebreakm_r;  // see RL18
  // A trapping stepped instruction ends the step just like a retired one.
  assign step_done = (state_r == dbg_pkg::ST_STEP) && (insn_retire || step_exception); // see RL8, RL9
  assign enter = !halted && (entry.trigger || ebreak_enter || entry.reset_halt
                             || entry.halt_req || step_done);
  assign csr_hit = csr_req.valid && addr_is_debug(csr_req.addr);
  assign wr_status = csr_hit && halted && csr_req.write
                     && (csr_req.addr == dbg_pkg::CSR_STATUS_ADDR);
  assign wr_pc = csr_hit && halted && csr_req.write
                 && (csr_req.addr == dbg_pkg::CSR_RESUME_PC_ADDR);

  // Priority picks both the cause code and the captured PC.
  // Keeping both choices in one chain guarantees that the PC always belongs to
  // the reason that the cause field reports, even when several fire at once.
  // A reset halt reports its own code rather than the halt-request code.
  always_comb begin
    cause_nxt = cause_r;
    capture_pc = entry.next_pc;  // see RL12
    if (entry.trigger) begin
      cause_nxt = dbg_pkg::CAUSE_TRIGGER;  // see RL3, RL4
      capture_pc = entry.trigger_timing ? entry.next_pc : entry.insn_pc;  // see RL17
    end else if (ebreak_enter) begin
      cause_nxt = dbg_pkg::CAUSE_EBREAK;
      capture_pc = entry.insn_pc;  // see RL15
    end else if (entry.reset_halt) begin
      cause_nxt = dbg_pkg::CAUSE_RESET;  // see RL5
    end else if (entry.halt_req) begin
      cause_nxt = dbg_pkg::CAUSE_HALTREQ;
    end else if (step_done) begin
      cause_nxt = dbg_pkg::CAUSE_STEP;
      capture_pc = step_next_pc;  // see RL16
    end
  end

  // The step state is kept apart from run so that exactly one retirement or
  // trap ends it; any other entry reason still wins while stepping.
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      dbg_pkg::ST_RUN: begin
        if (enter) begin
          state_nxt = dbg_pkg::ST_HALTED;
        end
      end
      dbg_pkg::ST_STEP: begin
        if (enter) begin
          state_nxt = dbg_pkg::ST_HALTED;
        end
      end
      dbg_pkg::ST_HALTED: begin
        if (resume_req) begin
          state_nxt = step_r ? dbg_pkg::ST_STEP : dbg_pkg::ST_RUN;  // see RL8
        end
      end
      default: state_nxt = dbg_pkg::ST_RUN;
    endcase
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_r <= dbg_pkg::ST_RUN;
    end else begin
      state_r <= state_nxt;
    end
  end

  // The cause is only loaded on entry, so it keeps reporting the last entry
  // reason for as long as the debugger needs it.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cause_r <= dbg_pkg::CAUSE_NONE;
    end else if (enter) begin
      cause_r <= cause_nxt;  // see RL20
    end
  end

  // The debugger write is only legal while halted, and entry cannot happen then.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      resume_pc_r <= dbg_pkg::RESUME_PC_RESET;
    end else if (enter) begin
      resume_pc_r <= capture_pc;  // see RL12, RL20
    end else if (wr_pc) begin
      resume_pc_r <= csr_req.wdata;  // see RL13
    end
  end

  // Step is only taken from debugger writes made while halted.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ebreakm_r <= 1'b0;
      stepie_r <= 1'b0;
      stopcount_r <= 1'b0;
      step_r <= 1'b0;
    end else if (wr_status) begin  // see RL10
      ebreakm_r <= csr_req.wdata[dbg_pkg::EBREAKM_BIT];
      stepie_r <= csr_req.wdata[dbg_pkg::STEPIE_BIT];
      stopcount_r <= csr_req.wdata[dbg_pkg::STOPCOUNT_BIT];
      step_r <= csr_req.wdata[dbg_pkg::STEP_BIT];
    end
  end

  // The pending level comes from a pin, so it is passed through two flops first.
  // Only the second flop is read; the status bit thus lags the pin by two cycles.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      nmi_meta_r <= 1'b0;
      nmi_sync_r <= 1'b0;
    end else begin
      nmi_meta_r <= nmi_pending;
      nmi_sync_r <= nmi_meta_r;
    end
  end

  // Unimplemented and reserved fields are tied to zero here, so writes to them
  // have no effect and reads never show stale values.
  always_comb begin
    status_view = '0;
    status_view[31:28] = dbg_pkg::DEBUGVER_VALUE;
    status_view[dbg_pkg::EBREAKM_BIT] = ebreakm_r;
    status_view[dbg_pkg::STEPIE_BIT] = stepie_r;
    status_view[dbg_pkg::STOPCOUNT_BIT] = stopcount_r;
    status_view[dbg_pkg::STOPTIME_BIT] = 1'b0;  // see RL2
    status_view[dbg_pkg::CAUSE_LSB +: 3] = cause_r;  // see RL3
    status_view[dbg_pkg::MPRVEN_BIT] = 1'b0;  // see RL6
    status_view[dbg_pkg::NMIP_BIT] = nmi_sync_r;  // see RL7
    status_view[dbg_pkg::STEP_BIT] = step_r;
    status_view[dbg_pkg::PRV_LSB +: 2] = dbg_pkg::PRV_MACHINE;  // see RL11
  end

  // Read data stands for one cycle and is zero otherwise, so a refused access
  // from machine mode can never leak register contents.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      csr_rdata <= 32'h0000_0000;
      illegal_insn <= 1'b0;
    end else begin
      illegal_insn <= csr_hit && !halted;  // see RL14
      if (csr_hit && halted) begin
        csr_rdata <= (csr_req.addr == dbg_pkg::CSR_STATUS_ADDR) ? status_view : resume_pc_r;
      end else begin
        csr_rdata <= 32'h0000_0000;
      end
    end
  end

  // debug_mode, mprv_ignore, count_stop and irq_mask are built from the next state so that they change in the same
  // cycle as the state register, at the cost of a longer path into the flops.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      debug_mode <= 1'b0;
      mprv_ignore <= 1'b0;
      count_stop <= 1'b0;
      irq_mask <= 1'b0;
      ebreak_to_debug <= 1'b0;
      ebreak_to_trap <= 1'b0;
    end else begin
      debug_mode <= (state_nxt == dbg_pkg::ST_HALTED);
      mprv_ignore <= (state_nxt == dbg_pkg::ST_HALTED);  // see RL6
      count_stop <= stopcount_r && ((state_nxt == dbg_pkg::ST_HALTED) || ebreak_enter); // see RL1
      irq_mask <= (state_nxt == dbg_pkg::ST_STEP) && !stepie_r;  // see RL19
      ebreak_to_debug <= ebreak_enter && !halted;  // see RL18
      ebreak_to_trap <= ebreak_exec && !ebreakm_r;
    end
  end

  // The core PC load is a one-cycle pulse; resume_pc itself holds until the next resume.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      resume_valid <= 1'b0;
      resume_pc <= dbg_pkg::RESUME_PC_RESET;
    end else begin
      resume_valid <= halted && resume_req;
      if (halted && resume_req) begin
        resume_pc <= resume_pc_r;  // see RL13
      end
    end
  end

endmodule

// ### debug_mode_ctrl_props.sv
/*
 * Concurrent checks on the debug control/status and resume-PC block.
 * Assumes it is bound to every instance of debug_mode_ctrl and sees only its ports.
 */
`timescale 1ns/1ps

module debug_mode_ctrl_props (
  input wire logic              ref_clk,
  input wire logic              rst,
  input wire dbg_pkg::entry_t   entry,
  input wire logic              ebreak_exec,
  input wire logic              resume_req,
  input wire dbg_pkg::csr_req_t csr_req,
  input wire logic              debug_mode,
  input wire logic              ebreak_to_debug,
  input wire logic              ebreak_to_trap,
  input wire logic              resume_valid,
  input wire logic [31:0]       resume_pc,
  input wire logic              count_stop,
  input wire logic              mprv_ignore,
  input wire logic              illegal_insn,
  input wire logic [31:0]       csr_rdata
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);

  halt_entry_a: assert property (
    !debug_mode && entry.halt_req |=> debug_mode) else $error("halt request not taken");
  resume_exit_a: assert property (
    debug_mode && resume_req |=> resume_valid && !debug_mode) else $error("resume not taken");
  halt_hold_a: assert property (
    debug_mode && !resume_req |=> debug_mode && $stable(resume_pc)) else $error("halt not held");
  resume_pulse_a: assert property (
    resume_valid |=> !resume_valid) else $error("resume pulse too long");
  illegal_csr_a: assert property (
    csr_req.valid && !debug_mode && (csr_req.addr == dbg_pkg::CSR_STATUS_ADDR ||
    csr_req.addr == dbg_pkg::CSR_RESUME_PC_ADDR) |=> illegal_insn) else $error("no illegal");
  legal_csr_a: assert property (
    csr_req.valid && debug_mode |=> !illegal_insn) else $error("illegal while halted");
  mprv_track_a: assert property (
    mprv_ignore == debug_mode) else $error("mprv ignore differs from debug mode");
  count_gate_a: assert property (
    count_stop |-> debug_mode || ebreak_to_debug) else $error("counters stopped while running");
  ebreak_route_a: assert property (
    ebreak_exec && !debug_mode && !entry.trigger |=> ebreak_to_debug != ebreak_to_trap)
    else $error("ebreak routed wrongly");
  rdata_idle_a: assert property (
    !csr_req.valid |=> csr_rdata == 32'h0000_0000) else $error("read data without request");
endmodule

bind debug_mode_ctrl debug_mode_ctrl_props i_props (.ref_clk(ref_clk), .rst(rst),
  .entry(entry), .ebreak_exec(ebreak_exec), .resume_req(resume_req), .csr_req(csr_req),
  .debug_mode(debug_mode), .ebreak_to_debug(ebreak_to_debug), .ebreak_to_trap(ebreak_to_trap),
  .resume_valid(resume_valid), .resume_pc(resume_pc), .count_stop(count_stop),
  .mprv_ignore(mprv_ignore), .illegal_insn(illegal_insn), .csr_rdata(csr_rdata));

// ### debug_mode_ctrl_tb_top.sv
/*
 * Self-checking testbench for debug_mode_ctrl.
 * Assumes the checker is bound to the design and the debugger model drives CSR traffic.
 */
`timescale 1ns/1ps

module debug_mode_ctrl_tb_top;
  logic              ref_clk, rst, ebreak_exec, insn_retire, step_exception, nmi_pending;
  logic              resume_req, debug_mode, ebreak_to_debug, ebreak_to_trap, resume_valid;
  logic              count_stop, irq_mask, mprv_ignore, illegal_insn, ill;
  logic [31:0]       step_next_pc, resume_pc, csr_rdata, rd, ctl;
  dbg_pkg::entry_t   entry;
  dbg_pkg::csr_req_t csr_req;
  int                num_errors, comparisons;
  localparam logic [11:0] ST = dbg_pkg::CSR_STATUS_ADDR;
  localparam logic [11:0] PC = dbg_pkg::CSR_RESUME_PC_ADDR;

  debug_mode_ctrl i_dut (.ref_clk(ref_clk), .rst(rst), .entry(entry), .ebreak_exec(ebreak_exec),
    .insn_retire(insn_retire), .step_exception(step_exception), .step_next_pc(step_next_pc),
    .resume_req(resume_req), .nmi_pending(nmi_pending), .csr_req(csr_req),
    .debug_mode(debug_mode), .ebreak_to_debug(ebreak_to_debug), .ebreak_to_trap(ebreak_to_trap),
    .resume_valid(resume_valid), .resume_pc(resume_pc), .count_stop(count_stop),
    .irq_mask(irq_mask), .mprv_ignore(mprv_ignore), .illegal_insn(illegal_insn),
    .csr_rdata(csr_rdata));
  dbg_host_model i_host (.ref_clk(ref_clk), .debug_mode(debug_mode), .csr_rdata(csr_rdata),
    .illegal_insn(illegal_insn), .csr_req(csr_req), .resume_req(resume_req));

  always #20 ref_clk = ~ref_clk;

  task automatic chk(logic [31:0] seen, logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic go(dbg_pkg::entry_t e, logic eb);
    @(posedge ref_clk);
    entry <= e;
    ebreak_exec <= eb;
    @(posedge ref_clk);
    entry <= '0;
    ebreak_exec <= 1'b0;
    #1;
  endtask

  task automatic pulse(logic ex, logic [31:0] npc);
    @(posedge ref_clk);
    insn_retire <= !ex;
    step_exception <= ex;
    step_next_pc <= npc;
    @(posedge ref_clk);
    insn_retire <= 1'b0;
    step_exception <= 1'b0;
    #1;
  endtask

  // Status expectation: version 4, privilege 3, the written control bits and the cause.
  task automatic halted(logic [2:0] cause, logic [31:0] pc);
    chk(debug_mode, 1'b1);
    chk(mprv_ignore, 1'b1);
    i_host.access(1'b0, ST, 32'h0000_0000, rd, ill);
    chk(rd, 32'h4000_0003 | ctl | {23'h0, cause, 6'h0});
    i_host.access(1'b0, PC, 32'h0000_0000, rd, ill);
    chk(rd, pc);
  endtask

  task automatic rs(logic [31:0] pc);
    i_host.resume();
    #1;
    chk(resume_pc, pc);
    chk(resume_valid, 1'b1);
    chk(debug_mode, 1'b0);
  endtask

  task automatic setctl(logic [31:0] v);
    ctl = v;
    i_host.access(1'b1, ST, v, rd, ill);
  endtask

  initial begin
    repeat (3000) @(posedge ref_clk);
    num_errors++;
    end_sim();
  end

  initial begin
    ref_clk = 1'b0;
    rst = 1'b1;
    entry = '0;
    ebreak_exec = 1'b0;
    insn_retire = 1'b0;
    step_exception = 1'b0;
    step_next_pc = 32'h0000_0000;
    nmi_pending = 1'b0;
    ctl = 32'h0000_0000;
    num_errors = 0;
    comparisons = 0;
    repeat (10) @(posedge ref_clk);
    rst <= 1'b0;
    i_host.access(1'b0, ST, 32'h0000_0000, rd, ill);
    chk(ill, 1'b1);
    chk(rd, 32'h0000_0000);
    go('{default: '0, halt_req: 1'b1, next_pc: 32'h0000_1000}, 1'b0);
    halted(3'h3, 32'h0000_1000);
    i_host.access(1'b1, PC, 32'h0000_2000, rd, ill);
    rs(32'h0000_2000);
    $display("test halt_request done");
    go('{default: '0, trigger: 1'b1, reset_halt: 1'b1, halt_req: 1'b1,
        insn_pc: 32'h0000_0100, next_pc: 32'h0000_0104}, 1'b1);
    halted(3'h2, 32'h0000_0100);
    rs(32'h0000_0100);
    go('{default: '0, reset_halt: 1'b1, halt_req: 1'b1, next_pc: 32'h0000_0108}, 1'b0);
    halted(3'h5, 32'h0000_0108);
    rs(32'h0000_0108);
    go('{default: '0, trigger: 1'b1, trigger_timing: 1'b1, insn_pc: 32'h0000_010c,
        next_pc: 32'h0000_0110}, 1'b0);
    halted(3'h2, 32'h0000_0110);
    $display("test entry_priority done");
    setctl(32'h0000_8400);
    @(posedge ref_clk);
    #1;
    chk(count_stop, 1'b1);
    rs(32'h0000_0110);
    go('{default: '0, insn_pc: 32'h0000_0200, next_pc: 32'h0000_0204}, 1'b1);
    chk(ebreak_to_debug, 1'b1);
    halted(3'h1, 32'h0000_0200);
    $display("test ebreak_entry done");
    setctl(32'h0000_0004);
    rs(32'h0000_0200);
    @(posedge ref_clk);
    #1;
    chk(irq_mask, 1'b1);
    pulse(1'b0, 32'h0000_0300);
    halted(3'h4, 32'h0000_0300);
    rs(32'h0000_0300);
    pulse(1'b1, 32'h0000_0400);
    halted(3'h4, 32'h0000_0400);
    $display("test single_step done");
    @(posedge ref_clk);
    nmi_pending <= 1'b1;
    repeat (4) @(posedge ref_clk);
    i_host.access(1'b0, ST, 32'h0000_0000, rd, ill);
    chk(rd[3], 1'b1);
    $display("test nmi_pending done");
    end_sim();
  end
endmodule
